// ---- bench/msc_properties.sv ----
// Concurrent checks on the muting controller ports
`timescale 1ns/10ps
`default_nettype none
module msc_properties
	import msc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [3:0] mute_pin,
	input wire logic curtain_on_pin,
	input wire logic suspend_o,
	input wire logic lamp_o,
	input wire logic override_o,
	input wire logic interlock_o,
	input wire logic lockout_o
);
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	logic take;
	logic [3:0] off_cnt_r;
	logic [3:0] cmd_age_r;

	assign take = hsel && hready && htrans[1];

	// Saturating, so a long off time never wraps to look recent
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			off_cnt_r <= 4'hF;
		else if (curtain_on_pin)
			off_cnt_r <= 4'h0;
		else if (off_cnt_r != 4'hF)
			off_cnt_r <= off_cnt_r + 4'h1;

	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			cmd_age_r <= 4'hF;
		else if (take && hwrite && haddr[7:0] == A_CMD)
			cmd_age_r <= 4'h0;
		else if (cmd_age_r != 4'hF)
			cmd_age_r <= cmd_age_r + 4'h1;

	a_bus_ready_okay: assert property ($past(hresetn) |-> hreadyout && !hresp)
		else $error("bus stalled or answered with error");
	a_cmd_reads_zero: assert property (take && !hwrite &&
		haddr == {24'h0, A_CMD} |=> hrdata == 32'h0)
		else $error("command register read not zero");
	// One cycle on so override_o has settled whatever its lag
	a_mute_needs_on: assert property ($rose(suspend_o) ##1 !override_o
		|-> off_cnt_r < 4'h8)
		else $error("muting began with curtain off");
	a_mute_needs_pair: assert property ($rose(suspend_o) ##1 !override_o
		|-> (mute_pin[0] | mute_pin[3]) && (mute_pin[1] | mute_pin[2]))
		else $error("muting began without both inputs");
	a_early_drop_ends: assert property ($fell(mute_pin[1]) && mute_pin[0] &&
		mute_pin[3:2] == 2'b00 && suspend_o && !override_o
		|-> ##[1:8] !suspend_o)
		else $error("muting kept after second input dropped");
	a_restart_needs_cmd: assert property ($fell(interlock_o) ||
		$fell(lockout_o) |-> cmd_age_r < 4'h6)
		else $error("interlock left without restart command");
	a_states_exclusive: assert property
		($onehot0({override_o, interlock_o, lockout_o}))
		else $error("override interlock lockout overlap");
	a_lamp_in_suspend: assert property (lamp_o |-> suspend_o || $past(suspend_o))
		else $error("lamp lit while not suspended");

	c_muting: cover property ($rose(suspend_o) ##1 !override_o);
	c_override: cover property ($rose(override_o));
	c_interlock: cover property ($rose(interlock_o));
endmodule // msc_properties
`default_nettype wire

// ---- bench/msc_sensor_model.sv ----
// Behavioural muting sensors with a fixed response lag
`timescale 1ns/10ps
`default_nettype none
module msc_sensor_model
#(
	parameter int LAG = 3
)
(
	input wire logic hclk,
	input wire logic [3:0] obj_seen,
	output logic [3:0] mute_pin
);
	logic [3:0] pipe_r [0:LAG-1];

	// A slow sensor: detection shows LAG clocks late
	always_ff @(posedge hclk)
	begin
		pipe_r[0] <= obj_seen;
		for (int i = 1; i < LAG; i++)
			pipe_r[i] <= pipe_r[i-1];
	end

	// High while the object was seen LAG clocks earlier
	assign mute_pin = pipe_r[LAG-1];
endmodule // msc_sensor_model
`default_nettype wire

// ---- bench/muting_sequence_controller_tb.sv ----
// Self-checking bench for the muting sequence controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) \
	begin \
		samples_checked++; \
		if ((s) !== (e)) \
		begin \
			miscompares++; \
			$display("Error %s expected %h seen %h", nm, e, s); \
		end \
	end
module muting_sequence_controller_tb;
	import msc_pkg::*;
	localparam int MS = 25;
	typedef struct {
		logic [7:0] a;
		logic w;
		logic [31:0] d;
		logic [31:0] e;
	} msc_row_t;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] obj_seen, mute_pin;
	logic [15:0] beam_pin;
	logic curtain_on_pin, curtain_free_pin, lamp_ok_pin, override_pin;
	logic suspend_o, lamp_o, override_o, interlock_o, lockout_o, intrusion_o;
	int miscompares, samples_checked;
	msc_row_t rows [0:20] = '{
		'{A_CTRL, 0, 0, 0}, '{A_GAPMIN, 0, 0, 32'h64},
		'{A_GAPMAX, 0, 0, 4}, '{A_MULT, 0, 0, 2}, '{A_FILT, 0, 0, 0},
		'{A_DYN, 0, 0, 32'h7D0}, '{A_TMO, 0, 0, 32'h258},
		'{A_OVTMO, 0, 0, 2}, '{A_CMD, 0, 0, 0}, '{8'h30, 0, 0, 0},
		'{A_GAPMAX, 1, 0, 1}, '{A_GAPMAX, 1, 32'h14, 32'h10},
		'{A_MULT, 1, 32'h11, 32'h10}, '{A_MULT, 1, 3, 3},
		'{A_GAPMIN, 1, 5, 32'hA}, '{A_GAPMIN, 1, 32'h3E9, 32'h3E8},
		'{A_GAPMIN, 1, 32'h32, 32'h32},
		'{A_FILT, 1, 32'h07D007D0, 32'h03E803E8}, '{A_FILT, 1, 0, 0},
		'{A_DYN, 1, 32'h701F4, 32'h601F4}, '{A_GAPMAX, 1, 1, 1}};

	assign hready = hreadyout;

	msc_top #(.MS_CYCLES(MS)) i_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .mute_pin(mute_pin), .beam_pin(beam_pin),
		.curtain_on_pin(curtain_on_pin), .curtain_free_pin(curtain_free_pin),
		.lamp_ok_pin(lamp_ok_pin), .override_pin(override_pin),
		.suspend_o(suspend_o), .lamp_o(lamp_o), .override_o(override_o),
		.interlock_o(interlock_o), .lockout_o(lockout_o),
		.intrusion_o(intrusion_o));

	msc_sensor_model #(.LAG(3)) i_sensors (
		.hclk(hclk), .obj_seen(obj_seen), .mute_pin(mute_pin));

	initial
	begin
		hclk = 1'b0;
		forever
			#20 hclk = ~hclk;
	end

	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		q = hrdata;
	endtask

	task automatic ms(input int n);
		repeat (n * MS) @(posedge hclk);
	endtask

	task automatic seq(input int a, input int b, input int gap);
		obj_seen[a] <= 1'b1;
		ms(gap);
		obj_seen[b] <= 1'b1;
		ms(5);
	endtask

	task automatic clr();
		obj_seen <= 4'h0;
		ms(5);
	endtask

	task automatic stop_test();
		$display("Checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Whole run needs about 1600 ms of device time
	initial
	begin
		ms(2000);
		miscompares++;
		stop_test();
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		{hresetn, hsel, hwrite, override_pin, curtain_free_pin} = 5'h0;
		{curtain_on_pin, lamp_ok_pin} = 2'h3;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'b00;
		hsize = 3'b010;
		beam_pin = 16'h0;
		obj_seen = 4'h0;
		miscompares = 0;
		samples_checked = 0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (rows[i])
		begin
			if (rows[i].w)
				bus(rows[i].a, 1'b1, rows[i].d);
			bus(rows[i].a, 1'b0, 32'h0);
			`CHK("register", rows[i].e, q);
		end
		bus(A_CTRL, 1'b1, 32'h1);
		seq(0, 1, 100);
		bus(A_STAT, 1'b0, 32'h0);
		`CHK("state", 8'h04, q[7:0]);
		bus(A_GAP, 1'b0, 32'h0);
		`CHK("gap", 1'b1, q >= 99 && q <= 101);
		obj_seen[0] <= 1'b0;
		ms(290);
		`CHK("suspend", 1'b1, suspend_o);
		ms(20);
		`CHK("suspend", 1'b0, suspend_o);
		clr();
		bus(A_STAT, 1'b0, 32'h0);
		`CHK("state", 8'h01, q[7:0]);
		seq(0, 1, 100);
		obj_seen[1] <= 1'b0;
		ms(1);
		`CHK("suspend", 1'b0, suspend_o);
		clr();
		for (int g = 0; g < 40; g += 20)
		begin
			seq(0, 1, g);
			`CHK("suspend", 1'b0, suspend_o);
			clr();
		end
		curtain_on_pin <= 1'b0;
		seq(0, 1, 100);
		`CHK("suspend", 1'b0, suspend_o);
		clr();
		curtain_on_pin <= 1'b1;
		bus(A_CTRL, 1'b1, 32'h5);
		seq(0, 1, 100);
		`CHK("suspend", 1'b1, suspend_o);
		curtain_free_pin <= 1'b1;
		ms(1);
		`CHK("suspend", 1'b0, suspend_o);
		curtain_free_pin <= 1'b0;
		clr();
		bus(A_CTRL, 1'b1, 32'h3);
		seq(3, 2, 100);
		`CHK("suspend", 1'b1, suspend_o);
		obj_seen[3] <= 1'b0;
		ms(1);
		`CHK("suspend", 1'b0, suspend_o);
		clr();
		lamp_ok_pin <= 1'b0;
		bus(A_CTRL, 1'b1, 32'h41);
		obj_seen[0] <= 1'b1;
		ms(1);
		`CHK("lockout", 1'b1, lockout_o);
		clr();
		lamp_ok_pin <= 1'b1;
		bus(A_CMD, 1'b1, 32'h3);
		ms(1);
		`CHK("lockout", 1'b0, lockout_o);
		curtain_on_pin <= 1'b0;
		bus(A_CTRL, 1'b1, 32'h181);
		obj_seen[0] <= 1'b1;
		ms(1);
		override_pin <= 1'b1;
		ms(1);
		override_pin <= 1'b0;
		ms(2);
		`CHK("override", 1'b1, override_o);
		obj_seen[0] <= 1'b0;
		ms(1);
		`CHK("interlock", 1'b1, interlock_o);
		bus(A_CMD, 1'b1, 32'h1);
		ms(1);
		`CHK("interlock", 1'b0, interlock_o);
		// Level override: override ends as soon as the operator releases the input
		bus(A_CTRL, 1'b1, 32'h1);
		obj_seen[0] <= 1'b1;
		ms(1);
		override_pin <= 1'b1;
		ms(2);
		`CHK("override", 1'b1, override_o);
		override_pin <= 1'b0;
		ms(1);
		`CHK("override", 1'b0, override_o);
		`CHK("interlock", 1'b0, interlock_o);
		clr();
		// Dynamic height from the top: taught height 1, tolerance 6
		curtain_on_pin <= 1'b1;
		beam_pin <= 16'h8000;
		bus(A_CTRL, 1'b1, 32'h31);
		seq(0, 1, 100);
		ms(510);
		`CHK("intrusion", 1'b0, intrusion_o);
		`CHK("suspend", 1'b1, suspend_o);
		beam_pin <= 16'h0080;
		ms(1);
		`CHK("intrusion", 1'b1, intrusion_o);
		`CHK("suspend", 1'b0, suspend_o);
		bus(A_CMD, 1'b1, 32'h2);
		ms(1);
		`CHK("intrusion", 1'b0, intrusion_o);
		stop_test();
	end
endmodule // muting_sequence_controller_tb

bind msc_top msc_properties i_props (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .mute_pin(mute_pin),
	.curtain_on_pin(curtain_on_pin), .suspend_o(suspend_o),
	.lamp_o(lamp_o), .override_o(override_o),
	.interlock_o(interlock_o), .lockout_o(lockout_o));
`default_nettype wire

// ---- logic/msc_filter.sv ----
// Synchroniser and activation/deactivation filter for one mute input
`timescale 1ns/10ps
`default_nettype none
module msc_filter
	import msc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic pin,
	input wire logic ms_tick,
	input wire logic [9:0] act_ms,
	input wire logic [9:0] deact_ms,
	output logic level
);
	logic sync_a_r;
	logic sync_b_r;
	logic [9:0] cnt_r;
	logic [9:0] limit;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sync_a_r <= 1'b0;
			sync_b_r <= 1'b0;
		end
		else
		begin
			sync_a_r <= pin;
			sync_b_r <= sync_a_r;
		end
	end

	// Deactivation and activation filters
	assign limit = level ? deact_ms : act_ms;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			level <= 1'b0;
			cnt_r <= 10'h000;
		end
		else if (sync_b_r == level)
			cnt_r <= 10'h000;
		else if (cnt_r >= limit)
		begin
			level <= sync_b_r;
			cnt_r <= 10'h000;
		end
		else if (ms_tick)
			cnt_r <= cnt_r + 10'h001;
	end

endmodule // msc_filter
`default_nettype wire

// ---- logic/msc_pkg.sv ----
// Package of constants and types for the muting sequence controller
`default_nettype none
package msc_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int MS_PER_S = 1000;
	localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
	localparam int S_PER_MIN = 60;
	localparam int NBEAMS = 16;

	// ------------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_GAPMIN = 8'h04;
	localparam logic [7:0] A_GAPMAX = 8'h08;
	localparam logic [7:0] A_MULT = 8'h0C;
	localparam logic [7:0] A_FILT = 8'h10;
	localparam logic [7:0] A_DYN = 8'h14;
	localparam logic [7:0] A_TMO = 8'h18;
	localparam logic [7:0] A_OVTMO = 8'h1C;
	localparam logic [7:0] A_CMD = 8'h20;
	localparam logic [7:0] A_STAT = 8'h24;
	localparam logic [7:0] A_GAP = 8'h28;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int F_DEACT = 16;
	localparam int F_TOL = 16;
	localparam int F_INTR = 8;
	localparam int F_LAMPF = 9;
	localparam int F_HGT = 16;
	localparam int K_RESTART = 0;
	localparam int K_CLRINT = 1;

	// ------------------------------------------------------------------
	// Reset values and ranges
	// ------------------------------------------------------------------
	localparam logic [9:0] GAPMIN_DEF = 10'd100;
	localparam int GAPMIN_LO = 10;
	localparam int GAPMIN_HI = 1000;
	localparam logic [4:0] GAPMAX_DEF = 5'd4;
	localparam logic [4:0] MULT_DEF = 5'd2;
	localparam int X16_LO = 1;
	localparam int X16_HI = 16;
	localparam logic [9:0] FILT_DEF = 10'd0;
	localparam int FILT_HI = 1000;
	localparam logic [11:0] TEACH_DEF = 12'd2000;
	localparam int TEACH_LO = 500;
	localparam int TEACH_HI = 4000;
	localparam logic [2:0] TOL_DEF = 3'd0;
	localparam int TOL_HI = 6;
	localparam logic [15:0] TMO_DEF = 16'd600;
	localparam int TMO_LO = 10;
	localparam int TMO_HI = 57600;
	localparam logic [8:0] OVTMO_DEF = 9'd2;
	localparam int OVTMO_HI = 256;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic ov_manual;
		logic ov_edge;
		logic lamp_chk;
		logic from_top;
		logic dyn;
		logic infinite;
		logic stop_free;
		logic four;
		logic en;
	} msc_cfg_t;

	localparam msc_cfg_t CFG_DEF = 9'h000;

	typedef enum logic [7:0] {
		S_IDLE = 8'h01,
		S_GAP = 8'h02,
		S_MUTE = 8'h04,
		S_RUN = 8'h08,
		S_WAIT = 8'h10,
		S_OVR = 8'h20,
		S_ILOCK = 8'h40,
		S_LOCK = 8'h80
	} msc_state_t;

	function automatic int msc_clamp(input int v, input int lo, input int hi);
		int r;
		r = v;
		if (v < lo)
			r = lo;
		else if (v > hi)
			r = hi;
		return r;
	endfunction

endpackage
`default_nettype wire

// ---- logic/msc_top.sv ----
// Muting sequence controller with AHB-Lite register slave
//
// Function
// - Muting requests are taken only while the curtain reports ON.
// - Protection is suspended after a valid, well timed sensor sequence, or while override is active.
// - Two-sensor one-way or four-sensor two-way mode, chosen by configuration.
// - Two-sensor: second follows first, gap above zero and below maximum.
// - Measured gap times multiplier gives the muting timer value.
// - Two-sensor: timer starts when first input drops; muting ends on expiry.
// - Second input dropping before first ends muting at once.
// - Stop setting: timer only, or timer or free curtain.
// - Minimum gap in ms, default 100, model-dependent lower bound.
// - Maximum gap 1 to 16 seconds, default 4.
// - Gap multiplier 1 to 16, default 2.
// - Deactivation filter 0 to 1000 ms, default 0.
// - Activation filter 0 to 1000 ms, default 0.
// - Dynamic muting limits height to beams taught within teach time.
// - Up to 6 extra beams above taught height tolerated.
// - Start-from-top reverses beam counting direction.
// - Lamp check verifies the external muting lamp before muting.
// - Edge override: sequence continues without held override input.
// - Automatic restart: outputs stay high and monitoring resumes.
// - Manual restart: interlock until restart command arrives.
`timescale 1ns/10ps
`default_nettype none
module msc_top
	import msc_pkg::*;
#(
	parameter int MS_CYCLES = msc_pkg::MS_CYCLES_DEF
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [3:0] mute_pin,
	input wire logic [msc_pkg::NBEAMS-1:0] beam_pin,
	input wire logic curtain_on_pin,
	input wire logic curtain_free_pin,
	input wire logic lamp_ok_pin,
	input wire logic override_pin,
	output logic suspend_o,
	output logic lamp_o,
	output logic override_o,
	output logic interlock_o,
	output logic lockout_o,
	output logic intrusion_o
);
	import msc_pkg::*;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	localparam logic [14:0] MS_LAST = 15'(MS_CYCLES - 1);
	localparam logic [9:0] MS_IN_S_LAST = 10'(MS_PER_S - 1);
	localparam int SW = NBEAMS + 4;

	msc_cfg_t cfg_r;
	msc_state_t state_r;
	logic [9:0] gapmin_r;
	logic [4:0] gapmax_r;
	logic [4:0] mult_r;
	logic [9:0] act_r;
	logic [9:0] deact_r;
	logic [11:0] teach_r;
	logic [2:0] tol_r;
	logic [15:0] tmo_r;
	logic [8:0] ovtmo_r;
	logic [SW-1:0] sync_a_r;
	logic [SW-1:0] sync_b_r;
	logic [14:0] ms_cnt_r;
	logic [9:0] ms_in_s_r;
	logic ms_tick;
	logic sec_tick;
	logic [3:0] mute_f;
	logic in_a;
	logic in_b;
	logic first_b_r;
	logic first_in;
	logic other_in;
	logic [13:0] gap_ms_r;
	logic [13:0] gap_hold_r;
	logic [13:0] gap_max_ms;
	logic [18:0] timer_r;
	logic [15:0] run_s_r;
	logic [11:0] teach_ms_r;
	logic [4:0] taught_r;
	logic [4:0] cur_h;
	logic [13:0] ovr_s_r;
	logic [13:0] ovr_lim;
	logic ovr_prev_r;
	logic ovr_rise;
	logic muting;
	logic teach_done;
	logic intr_hit;
	logic end_hit;
	logic ovr_end;
	logic restart_r;
	logic clrint_r;
	logic lampf_r;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic take;
	logic curtain_on;
	logic curtain_free;
	logic lamp_ok;
	logic ovr_lvl;
	logic [NBEAMS-1:0] beams;

	// Highest occupied beam, 1-based, 0 when clear
	function automatic logic [4:0] top_beam(input logic [NBEAMS-1:0] b,
		input logic from_top);
		logic [4:0] h;
		h = 5'h00;
		for (int i = 0; i < NBEAMS; i++)
		begin
			if (b[from_top ? NBEAMS - 1 - i : i])
				h = 5'(i + 1);
		end
		return h;
	endfunction

	// ------------------------------------------------------------------
	// Input synchronisers and time base
	// ------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sync_a_r <= '0;
			sync_b_r <= '0;
		end
		else
		begin
			sync_a_r <= {beam_pin, curtain_on_pin, curtain_free_pin,
				lamp_ok_pin, override_pin};
			sync_b_r <= sync_a_r;
		end
	end

	assign {beams, curtain_on, curtain_free, lamp_ok, ovr_lvl} = sync_b_r;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ms_cnt_r <= 15'h0000;
			ms_in_s_r <= 10'h000;
		end
		else if (ms_tick)
		begin
			ms_cnt_r <= 15'h0000;
			ms_in_s_r <= sec_tick ? 10'h000 : ms_in_s_r + 10'h001;
		end
		else
			ms_cnt_r <= ms_cnt_r + 15'h0001;
	end

	assign ms_tick = (ms_cnt_r == MS_LAST);
	assign sec_tick = ms_tick && (ms_in_s_r == MS_IN_S_LAST);

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_filt
			msc_filter u_filt (
				.hclk(hclk),
				.hresetn(hresetn),
				.pin(mute_pin[gi]),
				.ms_tick(ms_tick),
				.act_ms(act_r),
				.deact_ms(deact_r),
				.level(mute_f[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// Sequence decode
	// ------------------------------------------------------------------
	// Four-sensor mode pairs the outer and inner sensors of each side
	assign in_a = cfg_r.four ? (mute_f[0] | mute_f[3]) : mute_f[0];
	assign in_b = cfg_r.four ? (mute_f[1] | mute_f[2]) : mute_f[1];
	assign first_in = first_b_r ? in_b : in_a;
	assign other_in = first_b_r ? in_a : in_b;
	assign gap_max_ms = 14'(gapmax_r * MS_PER_S);
	assign ovr_lim = 14'(ovtmo_r * S_PER_MIN);
	assign muting = (state_r == S_MUTE) || (state_r == S_RUN);
	assign cur_h = top_beam(beams, cfg_r.from_top);
	assign teach_done = (teach_ms_r >= teach_r);
	assign intr_hit = cfg_r.dyn && teach_done &&
		(cur_h > 5'(taught_r + tol_r));
	assign end_hit = (!cfg_r.infinite && (run_s_r >= tmo_r)) ||
		(cfg_r.stop_free && curtain_free) || intr_hit;
	assign ovr_rise = ovr_lvl && !ovr_prev_r;
	assign ovr_end = (ovr_s_r >= ovr_lim) ||
		(!cfg_r.ov_edge && !ovr_lvl) ||
		(!in_a && !in_b);

	// ------------------------------------------------------------------
	// Muting state machine
	// ------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_r <= S_IDLE;
			first_b_r <= 1'b0;
			gap_hold_r <= 14'h0000;
			timer_r <= 19'h00000;
		end
		else
		begin
			unique case (state_r)
			S_IDLE:
				if (ovr_rise)
					state_r <= S_OVR;
				else if (cfg_r.en && curtain_on && (in_a || in_b))
				begin
					first_b_r <= in_b;
					if (cfg_r.lamp_chk && !lamp_ok)
						state_r <= S_LOCK;
					else if (in_a && in_b)
						state_r <= S_WAIT;
					else if (!cfg_r.four && in_b)
						state_r <= S_WAIT;
					else
						state_r <= S_GAP;
				end
			S_GAP:
				if (!curtain_on)
					state_r <= S_WAIT;
				else if (other_in)
				begin
					if (gap_ms_r >= 14'(gapmin_r) && gap_ms_r != 14'h0000 &&
						gap_ms_r < gap_max_ms)
					begin
						state_r <= S_MUTE;
						gap_hold_r <= gap_ms_r;
					end
					else
						state_r <= S_WAIT;
				end
				else if (!first_in || gap_ms_r >= gap_max_ms)
					state_r <= S_WAIT;
			S_MUTE:
				if (end_hit)
					state_r <= S_WAIT;
				else if (cfg_r.four && (!in_a || !in_b))
					state_r <= S_WAIT;
				else if (!cfg_r.four && in_a && !in_b)
					state_r <= S_WAIT;
				else if (!cfg_r.four && !in_a)
				begin
					state_r <= S_RUN;
					timer_r <= 19'(gap_hold_r * mult_r);
				end
			S_RUN:
				if (end_hit || timer_r == 19'h00000)
					state_r <= S_WAIT;
				else if (ms_tick)
					timer_r <= timer_r - 19'h00001;
			S_WAIT:
				if (ovr_rise)
					state_r <= S_OVR;
				else if (!in_a && !in_b)
					state_r <= S_IDLE;
			S_OVR:
				if (ovr_end)
					state_r <= cfg_r.ov_manual ? S_ILOCK : S_IDLE;
			S_ILOCK:
				if (restart_r)
					state_r <= S_IDLE;
			S_LOCK:
				if (restart_r)
					state_r <= S_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Sequence counters
	// ------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			gap_ms_r <= 14'h0000;
			run_s_r <= 16'h0000;
			teach_ms_r <= 12'h000;
			taught_r <= 5'h00;
			ovr_s_r <= 14'h0000;
			ovr_prev_r <= 1'b0;
		end
		else
		begin
			ovr_prev_r <= ovr_lvl;
			if (state_r != S_GAP)
				gap_ms_r <= 14'h0000;
			else if (ms_tick && gap_ms_r != 14'h3FFF)
				gap_ms_r <= gap_ms_r + 14'h0001;
			if (!muting)
				run_s_r <= 16'h0000;
			else if (sec_tick && run_s_r != 16'hFFFF)
				run_s_r <= run_s_r + 16'h0001;
			if (!muting)
				teach_ms_r <= 12'h000;
			else if (ms_tick && !teach_done)
				teach_ms_r <= teach_ms_r + 12'h001;
			if (!muting)
				taught_r <= 5'h00;
			else if (!teach_done && cur_h > taught_r)
				taught_r <= cur_h;
			if (state_r != S_OVR)
				ovr_s_r <= 14'h0000;
			else if (sec_tick && ovr_s_r != 14'h3FFF)
				ovr_s_r <= ovr_s_r + 14'h0001;
		end
	end

	// ------------------------------------------------------------------
	// Status flags and outputs
	// ------------------------------------------------------------------
	// Set wins over a software clear issued in the same cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			intrusion_o <= 1'b0;
			lampf_r <= 1'b0;
		end
		else
		begin
			if (muting && intr_hit)
				intrusion_o <= 1'b1;
			else if (clrint_r)
				intrusion_o <= 1'b0;
			if (state_r == S_LOCK)
				lampf_r <= 1'b1;
			else if (clrint_r)
				lampf_r <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			suspend_o <= 1'b0;
			lamp_o <= 1'b0;
			override_o <= 1'b0;
			interlock_o <= 1'b0;
			lockout_o <= 1'b0;
		end
		else
		begin
			suspend_o <= muting || (state_r == S_OVR);
			lamp_o <= (muting || (state_r == S_OVR)) && ms_in_s_r[9];
			override_o <= (state_r == S_OVR);
			interlock_o <= (state_r == S_ILOCK);
			lockout_o <= (state_r == S_LOCK);
		end
	end

	// ------------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// ------------------------------------------------------------------
	assign take = hsel && hready && htrans[1];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata <= 32'h00000000;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_r <= take && hwrite;
			if (take)
				wr_addr_r <= haddr[7:0];
			if (take && !hwrite && haddr[31:8] == 24'h000000)
			begin
				unique case (haddr[7:0])
				A_CTRL: hrdata <= 32'(cfg_r);
				A_GAPMIN: hrdata <= 32'(gapmin_r);
				A_GAPMAX: hrdata <= 32'(gapmax_r);
				A_MULT: hrdata <= 32'(mult_r);
				A_FILT: hrdata <= 32'(act_r) | (32'(deact_r) << F_DEACT);
				A_DYN: hrdata <= 32'(teach_r) | (32'(tol_r) << F_TOL);
				A_TMO: hrdata <= 32'(tmo_r);
				A_OVTMO: hrdata <= 32'(ovtmo_r);
				A_STAT: hrdata <= 32'(state_r) | (32'(intrusion_o) << F_INTR) |
					(32'(lampf_r) << F_LAMPF) | (32'(taught_r) << F_HGT);
				A_GAP: hrdata <= 32'(gap_hold_r);
				default: hrdata <= 32'h00000000;
				endcase
			end
			else if (take)
				hrdata <= 32'h00000000;
		end
	end

	// Out-of-range writes are clamped so the sequencer never sees them
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cfg_r <= CFG_DEF;
			gapmin_r <= GAPMIN_DEF;
			gapmax_r <= GAPMAX_DEF;
			mult_r <= MULT_DEF;
			act_r <= FILT_DEF;
			deact_r <= FILT_DEF;
			teach_r <= TEACH_DEF;
			tol_r <= TOL_DEF;
			tmo_r <= TMO_DEF;
			ovtmo_r <= OVTMO_DEF;
			restart_r <= 1'b0;
			clrint_r <= 1'b0;
		end
		else
		begin
			restart_r <= 1'b0;
			clrint_r <= 1'b0;
			if (wr_pend_r)
			begin
				unique case (wr_addr_r)
				A_CTRL: cfg_r <= msc_cfg_t'(hwdata[8:0]);
				A_GAPMIN: gapmin_r <= 10'(msc_clamp(int'(hwdata[15:0]),
					GAPMIN_LO, GAPMIN_HI));
				A_GAPMAX: gapmax_r <= 5'(msc_clamp(int'(hwdata[7:0]),
					X16_LO, X16_HI));
				A_MULT: mult_r <= 5'(msc_clamp(int'(hwdata[7:0]),
					X16_LO, X16_HI));
				A_FILT:
				begin
					act_r <= 10'(msc_clamp(int'(hwdata[15:0]), 0, FILT_HI));
					deact_r <= 10'(msc_clamp(int'(hwdata[31:16]), 0, FILT_HI));
				end
				A_DYN:
				begin
					teach_r <= 12'(msc_clamp(int'(hwdata[15:0]),
						TEACH_LO, TEACH_HI));
					tol_r <= 3'(msc_clamp(int'(hwdata[18:16]), 0, TOL_HI));
				end
				A_TMO: tmo_r <= 16'(msc_clamp(int'(hwdata[15:0]),
					TMO_LO, TMO_HI));
				A_OVTMO: ovtmo_r <= 9'(msc_clamp(int'(hwdata[8:0]),
					X16_LO, OVTMO_HI));
				A_CMD:
				begin
					restart_r <= hwdata[K_RESTART];
					clrint_r <= hwdata[K_CLRINT];
				end
				default: ;
				endcase
			end
		end
	end

endmodule // msc_top
`default_nettype wire
